// [logic/refresh_map.vh]
// Overview of operation
// - Up to sixteen tiles per scan line; stacked windows limited only by line count.
// - Tile arrangement is held fixed for all lines of a strip.
// - Strip header gives line count, tile count and next strip address halves.
// - Tile descriptors are consecutive: width, start word and bit, bits per pixel.
// - Fetch exactly the programmed word count; show only first to last bit.
// - Four border enables per tile: top, bottom, left, right.
// - Two-bit window status presented while the tile's pixels are output.
// - Byte-swapped and non-linear source layouts are addressed accordingly.
// - Zoom bit magnifies a tile by horizontal and vertical pixel replication.
// - Field background bit makes the tile show background colour.
// - Borders are one pixel wide, colour from one shared 8-bit register.
// - Uncovered area shows 8-bit background colour and causes no fetches.
// - 1, 2 and 4 bit pixels padded via three 8-bit map registers.
// - Window output starts and stops on any pixel.
// - First strip address from a register, later ones from the link field.
// - CPU parameter writes reach the active set only at vertical retrace.
// - Video DRAM shift-register load replaces word fetches when enabled.
// - Separate horizontal and vertical zoom factors, 1 to 64, in registers.
// - Window status drives two external palette select lines.
`ifndef REFRESH_MAP_VH
`define REFRESH_MAP_VH
// register indices
`define REG_FIRST_LO 4'h0
`define REG_FIRST_HI 4'h1
`define REG_BORDER 4'h2
`define REG_FIELD_BG 4'h3
`define REG_MAP1 4'h4
`define REG_MAP2 4'h5
`define REG_MAP4 4'h6
`define REG_ZOOM_H 4'h7
`define REG_ZOOM_V 4'h8
`define REG_CTRL 4'h9
`define REG_STATUS 4'hA
// control bits
`define CTRL_EN 0
`define CTRL_VDRAM 1
// header and descriptor lengths in words
`define HDR_WORDS 3'h4
`define DESC_WORDS 3'h5
// descriptor word 2 fields
`define D2_ADDR_HI 5:0
`define D2_FIRST 9:6
`define D2_LAST 13:10
// descriptor word 3 fields
`define D3_WORDS 7:0
`define D3_BPP 9:8
`define D3_TOP 10
`define D3_BOT 11
`define D3_LEFT 12
`define D3_RIGHT 13
// descriptor word 4 fields
`define D4_STATUS 1:0
`define D4_SWAP 2
`define D4_NONLIN 3
`define D4_ZOOM 4
`define D4_FIELD 5
// second bank offset of non-linear bit maps
`define NL_BANK_OFS 22'h002000
`endif

// [logic/screen_refresh_engine.v]
`timescale 1ns/100ps
`include "refresh_map.vh"
module screen_refresh_engine #(
    parameter MAX_TILES = 16,
    parameter PIX_DIV = 4
)
(
    // clock and reset
    input wire I_CLK,
    input wire I_RST,
    // register port
    input wire [3:0] I_REG_ADDR,
    input wire [15:0] I_REG_WDATA,
    input wire I_REG_WR,
    input wire I_REG_RD,
    output reg [15:0] O_REG_RDATA,
    // video timing pins
    input wire I_VRETRACE,
    input wire I_HSTART,
    // graphics memory
    output wire O_MEM_REQ,
    output wire O_MEM_XFER,
    output wire [21:0] O_MEM_ADDR,
    input wire I_MEM_VALID,
    input wire [15:0] I_MEM_DATA,
    // video output
    output reg [7:0] O_PIXEL,
    output reg O_PIX_VALID,
    output reg [1:0] O_WIN_STATUS,
    output reg O_IN_WINDOW
);

localparam S_IDLE = 3'h0;
localparam S_HDR = 3'h1;
localparam S_DESC = 3'h2;
localparam S_TILE = 3'h3;
localparam S_FETCH = 3'h4;
localparam S_EMIT = 3'h5;
localparam S_ADV = 3'h6;

// ==========================================
// pin synchronisers and pixel divider
reg vr_s1_reg, vr_s2_reg, vr_s3_reg, hs_s1_reg, hs_s2_reg, hs_s3_reg;
reg [7:0] div_reg;
wire vr_rise = vr_s2_reg & ~vr_s3_reg;
wire hs_rise = hs_s2_reg & ~hs_s3_reg;
wire pix_en = (div_reg == PIX_DIV - 1);

always @(posedge I_CLK)
begin
    if (I_RST)
    begin
        {vr_s1_reg, vr_s2_reg, vr_s3_reg} <= 3'h0;
        {hs_s1_reg, hs_s2_reg, hs_s3_reg} <= 3'h0;
        div_reg <= 8'h00;
    end
    else
    begin
        vr_s1_reg <= I_VRETRACE;
        vr_s2_reg <= vr_s1_reg;
        vr_s3_reg <= vr_s2_reg;
        hs_s1_reg <= I_HSTART;
        hs_s2_reg <= hs_s1_reg;
        hs_s3_reg <= hs_s2_reg;
        div_reg <= pix_en ? 8'h00 : div_reg + 8'h01;
    end
end

// ==========================================
// shadow and active register sets
reg [21:0] sh_first_reg, act_first_reg;
reg [7:0] sh_border_reg, act_border_reg, sh_bg_reg, act_bg_reg;
reg [7:0] sh_map1_reg, act_map1_reg, sh_map2_reg, act_map2_reg, sh_map4_reg, act_map4_reg;
reg [5:0] sh_zh_reg, act_zh_reg, sh_zv_reg, act_zv_reg;
reg [1:0] sh_ctrl_reg, act_ctrl_reg;
reg [2:0] state_reg;
reg [4:0] tidx_reg;

always @(posedge I_CLK)
begin
    if (I_RST)
    begin
        sh_first_reg <= 22'h000000;
        act_first_reg <= 22'h000000;
        {sh_border_reg, act_border_reg, sh_bg_reg, act_bg_reg} <= 32'h00000000;
        {sh_map1_reg, act_map1_reg, sh_map2_reg, act_map2_reg} <= 32'h00000000;
        {sh_map4_reg, act_map4_reg} <= 16'h0000;
        {sh_zh_reg, act_zh_reg, sh_zv_reg, act_zv_reg} <= 24'h000000;
        {sh_ctrl_reg, act_ctrl_reg} <= 4'h0;
        O_REG_RDATA <= 16'h0000;
    end
    else
    begin
        if (I_REG_WR)
        begin
            case (I_REG_ADDR)
                `REG_FIRST_LO: sh_first_reg[15:0] <= I_REG_WDATA;
                `REG_FIRST_HI: sh_first_reg[21:16] <= I_REG_WDATA[5:0];
                `REG_BORDER: sh_border_reg <= I_REG_WDATA[7:0];
                `REG_FIELD_BG: sh_bg_reg <= I_REG_WDATA[7:0];
                `REG_MAP1: sh_map1_reg <= I_REG_WDATA[7:0];
                `REG_MAP2: sh_map2_reg <= I_REG_WDATA[7:0];
                `REG_MAP4: sh_map4_reg <= I_REG_WDATA[7:0];
                `REG_ZOOM_H: sh_zh_reg <= I_REG_WDATA[5:0];
                `REG_ZOOM_V: sh_zv_reg <= I_REG_WDATA[5:0];
                `REG_CTRL: sh_ctrl_reg <= I_REG_WDATA[1:0];
                default: sh_ctrl_reg <= sh_ctrl_reg;
            endcase
        end
        if (vr_rise)
        begin
            act_first_reg <= sh_first_reg;
            act_border_reg <= sh_border_reg;
            act_bg_reg <= sh_bg_reg;
            act_map1_reg <= sh_map1_reg;
            act_map2_reg <= sh_map2_reg;
            act_map4_reg <= sh_map4_reg;
            act_zh_reg <= sh_zh_reg;
            act_zv_reg <= sh_zv_reg;
            act_ctrl_reg <= sh_ctrl_reg;
        end
        if (I_REG_RD)
        begin
            case (I_REG_ADDR)
                `REG_FIRST_LO: O_REG_RDATA <= sh_first_reg[15:0];
                `REG_FIRST_HI: O_REG_RDATA <= {10'h000, sh_first_reg[21:16]};
                `REG_BORDER: O_REG_RDATA <= {8'h00, sh_border_reg};
                `REG_FIELD_BG: O_REG_RDATA <= {8'h00, sh_bg_reg};
                `REG_MAP1: O_REG_RDATA <= {8'h00, sh_map1_reg};
                `REG_MAP2: O_REG_RDATA <= {8'h00, sh_map2_reg};
                `REG_MAP4: O_REG_RDATA <= {8'h00, sh_map4_reg};
                `REG_ZOOM_H: O_REG_RDATA <= {10'h000, sh_zh_reg};
                `REG_ZOOM_V: O_REG_RDATA <= {10'h000, sh_zv_reg};
                `REG_CTRL: O_REG_RDATA <= {14'h0000, sh_ctrl_reg};
                `REG_STATUS: O_REG_RDATA <= {5'h00, O_IN_WINDOW, state_reg, 2'h0, tidx_reg};
                default: O_REG_RDATA <= 16'h0000;
            endcase
        end
    end
end

// ==========================================
// strip walker
reg [15:0] t_width [0:MAX_TILES-1];
reg [21:0] t_row [0:MAX_TILES-1];
reg [15:0] t_d2 [0:MAX_TILES-1];
reg [15:0] t_d3 [0:MAX_TILES-1];
reg [15:0] t_d4 [0:MAX_TILES-1];
reg [21:0] strip_ptr_reg, next_ptr_reg, fa_reg, waddr_reg;
reg [15:0] lines_left_reg, line_idx_reg, sh_reg;
reg [4:0] ntiles_reg, bits_left_reg;
reg [2:0] widx_reg;
reg [5:0] vrep_reg, hrep_reg;
reg [7:0] words_left_reg;
reg first_word_reg, pix_first_reg;

wire [15:0] d2 = t_d2[tidx_reg[3:0]];
wire [15:0] d3 = t_d3[tidx_reg[3:0]];
wire [15:0] d4 = t_d4[tidx_reg[3:0]];
wire vdram = act_ctrl_reg[`CTRL_VDRAM];
wire field_tile = d4[`D4_FIELD];
wire odd_line = line_idx_reg[0];
wire [4:0] bpp = 5'h01 << d3[`D3_BPP];
wire [3:0] bit_lo = first_word_reg ? d2[`D2_FIRST] : 4'h0;
wire [3:0] bit_hi = (words_left_reg == 8'h01) ? d2[`D2_LAST] : 4'hF;
wire [4:0] bit_cnt = {1'b0, bit_hi} - {1'b0, bit_lo} + 5'h01;
wire [15:0] word_in = d4[`D4_SWAP] ? {I_MEM_DATA[7:0], I_MEM_DATA[15:8]} : I_MEM_DATA;
wire fetch_wait = ~field_tile & (~vdram | first_word_reg);
wire word_ok = field_tile | I_MEM_VALID;
wire rep_done = ~d4[`D4_ZOOM] | (hrep_reg == act_zh_reg);
wire word_end = rep_done & ({1'b0, bits_left_reg} < {bpp, 1'b0});
wire row_step = (~d4[`D4_ZOOM] | (vrep_reg == act_zv_reg)) & (~d4[`D4_NONLIN] | odd_line);

assign O_MEM_REQ = (state_reg == S_HDR) | (state_reg == S_DESC)
    | ((state_reg == S_FETCH) & fetch_wait);
assign O_MEM_XFER = (state_reg == S_FETCH) & vdram & first_word_reg & ~field_tile;
assign O_MEM_ADDR = (state_reg == S_FETCH) ? waddr_reg : fa_reg;

// pixel colour of the current emit slot
reg [7:0] colour;
always @*
begin
    colour = 8'h00;
    case (d3[`D3_BPP])
        2'h0: colour = {act_map1_reg[7:1], sh_reg[15]};
        2'h1: colour = {act_map2_reg[7:2], sh_reg[15:14]};
        2'h2: colour = {act_map4_reg[7:4], sh_reg[15:12]};
        default: colour = sh_reg[15:8];
    endcase
    if (field_tile)
        colour = act_bg_reg;
    if ((pix_first_reg & d3[`D3_LEFT]) | (words_left_reg == 8'h00 & word_end & d3[`D3_RIGHT])
        | (line_idx_reg == 16'h0000 & d3[`D3_TOP]) | (lines_left_reg == 16'h0001 & d3[`D3_BOT]))
        colour = act_border_reg;
end

always @(posedge I_CLK)
begin
    if (I_RST)
    begin
        state_reg <= S_IDLE;
        {strip_ptr_reg, next_ptr_reg, fa_reg, waddr_reg} <= 88'h0;
        {lines_left_reg, line_idx_reg, sh_reg} <= 48'h0;
        {ntiles_reg, bits_left_reg, widx_reg, tidx_reg} <= 18'h00000;
        {vrep_reg, hrep_reg, words_left_reg} <= 20'h00000;
        {first_word_reg, pix_first_reg} <= 2'h0;
        O_PIXEL <= 8'h00;
        O_PIX_VALID <= 1'b0;
        O_WIN_STATUS <= 2'h0;
        O_IN_WINDOW <= 1'b0;
    end
    else if (vr_rise)
    begin
        state_reg <= S_IDLE;
        strip_ptr_reg <= sh_first_reg;
        lines_left_reg <= 16'h0000;
        O_PIX_VALID <= pix_en;
        O_IN_WINDOW <= 1'b0;
    end
    else
    begin
        O_PIX_VALID <= pix_en;
        if (pix_en & (state_reg != S_EMIT))
        begin
            O_PIXEL <= act_bg_reg;
            O_IN_WINDOW <= 1'b0;
        end
        case (state_reg)
            S_IDLE:
            begin
                tidx_reg <= 5'h00;
                widx_reg <= 3'h0;
                fa_reg <= strip_ptr_reg;
                if (hs_rise & act_ctrl_reg[`CTRL_EN])
                    state_reg <= (lines_left_reg == 16'h0000) ? S_HDR : S_TILE;
            end
            S_HDR:
                if (I_MEM_VALID)
                begin
                    fa_reg <= fa_reg + 22'h000001;
                    widx_reg <= widx_reg + 3'h1;
                    case (widx_reg)
                        3'h0: lines_left_reg <= (I_MEM_DATA == 16'h0000) ? 16'h0001 : I_MEM_DATA;
                        3'h1: ntiles_reg <= (I_MEM_DATA > MAX_TILES) ? MAX_TILES[4:0] : I_MEM_DATA[4:0];
                        3'h2: next_ptr_reg[15:0] <= I_MEM_DATA;
                        default: next_ptr_reg[21:16] <= I_MEM_DATA[5:0];
                    endcase
                    if (widx_reg == `HDR_WORDS - 3'h1)
                    begin
                        widx_reg <= 3'h0;
                        line_idx_reg <= 16'h0000;
                        vrep_reg <= 6'h00;
                        state_reg <= (ntiles_reg == 5'h00 && I_MEM_DATA == 16'h0000 && 1'b0)
                            ? S_TILE : S_DESC;
                        if (ntiles_reg == 5'h00)
                            state_reg <= S_TILE;
                    end
                end
            S_DESC:
                if (I_MEM_VALID)
                begin
                    fa_reg <= fa_reg + 22'h000001;
                    widx_reg <= widx_reg + 3'h1;
                    case (widx_reg)
                        3'h0: t_width[tidx_reg[3:0]] <= I_MEM_DATA;
                        3'h1: t_row[tidx_reg[3:0]][15:0] <= I_MEM_DATA;
                        3'h2:
                        begin
                            t_d2[tidx_reg[3:0]] <= I_MEM_DATA;
                            t_row[tidx_reg[3:0]][21:16] <= I_MEM_DATA[`D2_ADDR_HI];
                        end
                        3'h3: t_d3[tidx_reg[3:0]] <= I_MEM_DATA;
                        default: t_d4[tidx_reg[3:0]] <= I_MEM_DATA;
                    endcase
                    if (widx_reg == `DESC_WORDS - 3'h1)
                    begin
                        widx_reg <= 3'h0;
                        tidx_reg <= tidx_reg + 5'h01;
                        if (tidx_reg + 5'h01 == ntiles_reg)
                        begin
                            tidx_reg <= 5'h00;
                            state_reg <= S_TILE;
                        end
                    end
                end
            S_TILE:
                if (tidx_reg == ntiles_reg)
                begin
                    tidx_reg <= 5'h00;
                    state_reg <= S_ADV;
                end
                else if (d3[`D3_WORDS] == 8'h00)
                    tidx_reg <= tidx_reg + 5'h01;
                else
                begin
                    words_left_reg <= d3[`D3_WORDS];
                    first_word_reg <= 1'b1;
                    pix_first_reg <= 1'b1;
                    hrep_reg <= 6'h00;
                    waddr_reg <= t_row[tidx_reg[3:0]]
                        + ((d4[`D4_NONLIN] & odd_line) ? `NL_BANK_OFS : 22'h000000);
                    state_reg <= S_FETCH;
                end
            S_FETCH:
                if (word_ok)
                begin
                    sh_reg <= word_in << bit_lo;
                    bits_left_reg <= bit_cnt;
                    words_left_reg <= words_left_reg - 8'h01;
                    waddr_reg <= waddr_reg + 22'h000001;
                    first_word_reg <= 1'b0;
                    state_reg <= S_EMIT;
                end
            S_EMIT:
                if (pix_en)
                begin
                    O_PIXEL <= colour;
                    O_WIN_STATUS <= d4[`D4_STATUS];
                    O_IN_WINDOW <= 1'b1;
                    pix_first_reg <= 1'b0;
                    hrep_reg <= rep_done ? 6'h00 : hrep_reg + 6'h01;
                    if (rep_done)
                    begin
                        sh_reg <= sh_reg << bpp;
                        bits_left_reg <= bits_left_reg - bpp;
                    end
                    if (word_end | (bits_left_reg < bpp))
                    begin
                        if (words_left_reg == 8'h00)
                        begin
                            tidx_reg <= tidx_reg + 5'h01;
                            state_reg <= S_TILE;
                        end
                        else
                            state_reg <= S_FETCH;
                    end
                end
            S_ADV:
                if (tidx_reg == ntiles_reg)
                begin
                    vrep_reg <= (vrep_reg == act_zv_reg) ? 6'h00 : vrep_reg + 6'h01;
                    line_idx_reg <= line_idx_reg + 16'h0001;
                    lines_left_reg <= lines_left_reg - 16'h0001;
                    if (lines_left_reg == 16'h0001)
                        strip_ptr_reg <= next_ptr_reg;
                    state_reg <= S_IDLE;
                end
                else
                begin
                    if (row_step)
                        t_row[tidx_reg[3:0]] <= t_row[tidx_reg[3:0]]
                            + {6'h00, t_width[tidx_reg[3:0]]};
                    tidx_reg <= tidx_reg + 5'h01;
                end
            default: state_reg <= S_IDLE;
        endcase
    end
end

endmodule

// [bench/screen_refresh_engine_asserts.sv]
`timescale 1ns/100ps
module refresh_engine_checker #(
    parameter PIX_DIV = 4
)
(
    // watched ports
    input wire I_CLK,
    input wire I_RST,
    input wire [3:0] I_REG_ADDR,
    input wire [15:0] I_REG_WDATA,
    input wire I_REG_WR,
    input wire I_REG_RD,
    input wire [15:0] O_REG_RDATA,
    input wire I_VRETRACE,
    input wire I_MEM_VALID,
    input wire O_MEM_REQ,
    input wire O_MEM_XFER,
    input wire [21:0] O_MEM_ADDR,
    input wire [7:0] O_PIXEL,
    input wire O_PIX_VALID
);
    reg armed_reg;
    reg seen_reg;
    reg [7:0] gap_reg;
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);
    // ==========================================
    // retrace seen, pixel slot spacing
    always @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            armed_reg <= 1'b0;
            seen_reg <= 1'b0;
            gap_reg <= 8'h00;
        end
        else
        begin
            armed_reg <= armed_reg | I_VRETRACE;
            seen_reg <= seen_reg | O_PIX_VALID;
            gap_reg <= O_PIX_VALID ? 8'h00 : gap_reg + 8'h01;
        end
    end
    a_req_holds: assert property (
        O_MEM_REQ && !I_MEM_VALID |=> O_MEM_REQ && $stable(O_MEM_ADDR))
        else $error("memory request dropped or moved before answer");
    a_pix_spacing: assert property (
        O_PIX_VALID && seen_reg |-> gap_reg == PIX_DIV - 1)
        else $error("pixel slots not evenly spaced");
    a_unmapped_zero: assert property (
        I_REG_RD && I_REG_ADDR > 4'hA |=> O_REG_RDATA == 16'h0000)
        else $error("unmapped read not zero");
    a_rdata_holds: assert property (
        !I_REG_RD |=> $stable(O_REG_RDATA))
        else $error("read data changed without a read");
    a_border_readback: assert property (
        I_REG_WR && I_REG_ADDR == 4'h2 ##1 I_REG_RD && I_REG_ADDR == 4'h2
        |=> O_REG_RDATA == ($past(I_REG_WDATA, 2) & 16'h00FF))
        else $error("border colour readback wrong");
    a_reset_quiet: assert property (
        $fell(I_RST) |-> !O_MEM_REQ && !O_PIX_VALID && O_PIXEL == 8'h00)
        else $error("outputs active right after reset");
    a_xfer_in_req: assert property (
        O_MEM_XFER |-> O_MEM_REQ)
        else $error("shift load flag without request");
    a_idle_no_fetch: assert property (
        !armed_reg |-> !O_MEM_REQ)
        else $error("fetch before first retrace");
    a_pixel_on_slot: assert property (
        $changed(O_PIXEL) |-> O_PIX_VALID)
        else $error("pixel changed outside a slot");
endmodule

// [bench/refresh_mem_model.sv]
`timescale 1ns/100ps
module refresh_mem_model
(
    // memory side of the engine
    input wire i_clk,
    input wire i_req,
    input wire [21:0] i_addr,
    input wire i_slow,
    output reg o_valid = 1'b0,
    output reg [15:0] o_data = 16'h5555
);
    reg [15:0] mem [0:255];
    reg [1:0] wait_reg = 2'h0;
    // ==========================================
    // answer at once or after three stall cycles; data toggles when idle
    always @(posedge i_clk)
    begin
        o_valid <= 1'b0;
        o_data <= ~o_data;
        if (i_req && !o_valid)
        begin
            if (wait_reg == (i_slow ? 2'h3 : 2'h0))
            begin
                o_valid <= 1'b1;
                o_data <= mem[i_addr[7:0]];
                wait_reg <= 2'h0;
            end
            else
                wait_reg <= wait_reg + 2'h1;
        end
    end
endmodule

// [bench/tb_strip_tile_display_list_walker.sv]
`timescale 1ns/100ps
module tb_strip_tile_display_list_walker;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg [3:0] reg_addr = 4'h0;
    reg [15:0] reg_wdata = 16'h0000;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg vretrace = 1'b0;
    reg hstart = 1'b0;
    reg slow = 1'b0;
    wire [15:0] reg_rdata;
    wire mem_req;
    wire mem_xfer;
    wire [21:0] mem_addr;
    wire mem_valid;
    wire [15:0] mem_data;
    wire [7:0] pixel;
    wire pix_valid;
    wire [1:0] win_status;
    wire in_window;
    integer failures = 0;
    integer samples_checked = 0;
    integer words = 0;
    integer win_n = 0;
    reg [7:0] win_q [0:15];
    reg [7:0] exp_bg = 8'h00;
    reg mon_on = 1'b0;
    reg exp_xfer = 1'b0;
    always #5 clk = ~clk;
    screen_refresh_engine #(.MAX_TILES(16), .PIX_DIV(4)) dut_u (.I_CLK(clk), .I_RST(rst),
        .I_REG_ADDR(reg_addr), .I_REG_WDATA(reg_wdata), .I_REG_WR(reg_wr), .I_REG_RD(reg_rd),
        .O_REG_RDATA(reg_rdata), .I_VRETRACE(vretrace), .I_HSTART(hstart), .O_MEM_REQ(mem_req),
        .O_MEM_XFER(mem_xfer), .O_MEM_ADDR(mem_addr), .I_MEM_VALID(mem_valid),
        .I_MEM_DATA(mem_data), .O_PIXEL(pixel), .O_PIX_VALID(pix_valid),
        .O_WIN_STATUS(win_status), .O_IN_WINDOW(in_window));
    refresh_mem_model mem_u (.i_clk(clk), .i_req(mem_req), .i_addr(mem_addr),
        .i_slow(slow), .o_valid(mem_valid), .o_data(mem_data));
    task automatic check(input [31:0] got, input [31:0] exp);
    begin
        samples_checked = samples_checked + 1;
        if (got !== exp)
        begin
            failures = failures + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask
    task end_of_test;
    begin
        $display("compares=%0d mismatches=%0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    end
    endtask
    // ==========================================
    // memory and pixel monitor
    always @(posedge clk)
    begin
        if (mon_on && mem_req && mem_valid)
        begin
            if (words == 0)
                check(mem_addr, 22'h000010);
            if (words == 9)
                check(mem_xfer, exp_xfer);
            words = words + 1;
        end
        if (mon_on && pix_valid && in_window && win_n < 16)
        begin
            win_q[win_n] = pixel;
            win_n = win_n + 1;
        end
        else if (mon_on && pix_valid)
            check(pixel, exp_bg);
    end
    task reg_write(input [3:0] a, input [15:0] d);
    begin
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    end
    endtask
    function [15:0] mask_of(input [3:0] a);
        case (a)
            4'h0: mask_of = 16'hFFFF;
            4'h1, 4'h7, 4'h8: mask_of = 16'h003F;
            4'h2, 4'h3, 4'h4, 4'h5, 4'h6: mask_of = 16'h00FF;
            4'h9: mask_of = 16'h0003;
            default: mask_of = 16'h0000;
        endcase
    endfunction
    // ==========================================
    // write all ones then read straight back, unmapped included
    task t_regs;
        integer i;
    begin
        for (i = 0; i < 16; i = i + 1)
        begin
            if (i != 10)
            begin
                @(posedge clk);
                reg_addr <= i[3:0];
                reg_wdata <= 16'hFFFF;
                reg_wr <= 1'b1;
                @(posedge clk);
                reg_wr <= 1'b0;
                reg_rd <= 1'b1;
                @(posedge clk);
                reg_rd <= 1'b0;
                #1 check(reg_rdata, mask_of(i[3:0]));
            end
        end
    end
    endtask
    task retrace;
    begin
        @(posedge clk);
        vretrace <= 1'b1;
        repeat (4) @(posedge clk);
        vretrace <= 1'b0;
        repeat (4) @(posedge clk);
    end
    endtask
    // one-line strip, one 1 bpp tile of five pixels with left border
    task t_line(input [7:0] bg, input s);
        integer i;
    begin
        exp_bg = bg;
        slow <= s;
        words = 0;
        win_n = 0;
        mon_on = 1'b1;
        @(posedge clk);
        hstart <= 1'b1;
        repeat (4) @(posedge clk);
        hstart <= 1'b0;
        for (i = 0; i < 600 && win_n < 5; i = i + 1)
            @(posedge clk);
        repeat (40) @(posedge clk);
        mon_on = 1'b0;
        check(words, 10);
        check(win_n, 5);
        check(win_q[0], 8'h5A);
        check(win_q[1], 8'hA5);
        for (i = 2; i < 5; i = i + 1)
            check(win_q[i], 8'hA4);
        check(win_status, 2'b10);
    end
    endtask
    initial
    begin
        mem_u.mem[8'h10] = 16'h0001;
        mem_u.mem[8'h11] = 16'h0001;
        mem_u.mem[8'h12] = 16'h0010;
        mem_u.mem[8'h13] = 16'h0000;
        mem_u.mem[8'h14] = 16'h0001;
        mem_u.mem[8'h15] = 16'h0040;
        mem_u.mem[8'h16] = 16'h1000;
        mem_u.mem[8'h17] = 16'h1001;
        mem_u.mem[8'h18] = 16'h0002;
        mem_u.mem[8'h40] = 16'h4000;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        #1 check({mem_req, pix_valid, pixel}, 10'h000);
        t_regs;
        reg_write(4'h0, 16'h0010);
        reg_write(4'h1, 16'h0000);
        reg_write(4'h2, 16'h005A);
        reg_write(4'h3, 16'h003C);
        reg_write(4'h4, 16'h00A4);
        reg_write(4'h7, 16'h0000);
        reg_write(4'h9, 16'h0001);
        retrace;
        t_line(8'h3C, 1'b0);
        t_line(8'h3C, 1'b1);
        reg_write(4'h3, 16'h00C3);
        t_line(8'h3C, 1'b0);
        retrace;
        t_line(8'hC3, 1'b0);
        reg_write(4'h9, 16'h0003);
        retrace;
        exp_xfer = 1'b1;
        t_line(8'hC3, 1'b0);
        end_of_test;
    end
    initial
    begin
        #200000;
        failures = failures + 1;
        end_of_test;
    end
endmodule
bind screen_refresh_engine refresh_engine_checker #(.PIX_DIV(PIX_DIV)) chk_u (
    .I_CLK(I_CLK), .I_RST(I_RST), .I_REG_ADDR(I_REG_ADDR), .I_REG_WDATA(I_REG_WDATA),
    .I_REG_WR(I_REG_WR), .I_REG_RD(I_REG_RD), .O_REG_RDATA(O_REG_RDATA),
    .I_VRETRACE(I_VRETRACE), .I_MEM_VALID(I_MEM_VALID), .O_MEM_REQ(O_MEM_REQ),
    .O_MEM_XFER(O_MEM_XFER), .O_MEM_ADDR(O_MEM_ADDR), .O_PIXEL(O_PIXEL),
    .O_PIX_VALID(O_PIX_VALID));
